// *** core/drr_pkg.sv ***
// Shared constants, types and ECC functions of the dual-port RAM block
package drr_pkg;
  localparam int DATA_W        = 72;
  localparam int LOW_W         = 64;
  localparam int BYTE_N        = 9;
  localparam int ADDR_W        = 12;
  localparam int WORDS         = 4096;
  localparam int GRP_W         = 288;
  localparam int GRP_N         = 1024;
  localparam int GRP_WORDS     = 4;
  localparam int CHK_W         = 7;
  localparam int STAGE_MAX     = 3;
  localparam int SLEEP_LAT_MIN = 3;
  localparam int SLEEP_LAT_MAX = 15;
  localparam int SLEEP_LAT_DEF = 8;
  localparam int SYNC_LEN      = 2;
  localparam logic [DATA_W-1:0] DOUT_RST = 72'h0;

  typedef enum {CAS_NONE, CAS_FIRST, CAS_MIDDLE, CAS_LAST} drr_cas_t;
  typedef enum {BWE_INTERLEAVED, BWE_INDEPENDENT} drr_bwe_t;
  typedef logic [DATA_W-1:0] drr_word_t;

  // Hamming over positions 1..71, data on non-powers of two, top bit overall parity
  function automatic drr_word_t drr_ecc_enc(input logic [LOW_W-1:0] d);
    logic [CHK_W-1:0] c;
    int               k;
    c = '0;
    k = 0;
    for (int p = 1; p < DATA_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < CHK_W; i++) begin
          if (p[i]) c[i] = c[i] ^ d[k];
        end
        k++;
      end
    end
    return {^{c, d}, c, d};
  endfunction : drr_ecc_enc

  // Returns {double, single, corrected word}; triple errors are not told apart
  function automatic logic [DATA_W+1:0] drr_ecc_dec(input drr_word_t w);
    drr_word_t        r;
    logic [CHK_W-1:0] syn;
    logic             ovr;
    int               k;
    r   = drr_ecc_enc(w[LOW_W-1:0]);
    syn = r[LOW_W+CHK_W-1:LOW_W] ^ w[LOW_W+CHK_W-1:LOW_W];
    ovr = ^w;
    r   = w;
    k   = 0;
    for (int p = 1; p < DATA_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (ovr && syn == p[CHK_W-1:0]) r[k] = ~w[k];
        k++;
      end
    end
    return {(syn != '0) && !ovr, ovr, r};
  endfunction : drr_ecc_dec
endpackage : drr_pkg

// *** core/drr_if.sv ***
// Port bundle between the fabric and the dual-port RAM block
`timescale 1ns/1ps
interface drr_if (
  input wire logic ref_clk
);
  logic [1:0]                            en;
  logic [1:0]                            dirSel;
  logic [1:0]                            clr;
  logic [1:0]                            eccCe;
  logic [1:0][drr_pkg::ADDR_W-1:0]       addr;
  logic [1:0][drr_pkg::DATA_W-1:0]       din;
  logic [1:0][drr_pkg::BYTE_N-1:0]       bwe;
  wire logic [1:0][drr_pkg::DATA_W-1:0]  dout;
  wire logic [1:0]                       rdDone;
  wire logic [1:0]                       sbErr;
  wire logic [1:0]                       dbErr;

  modport dev (input ref_clk, en, dirSel, addr, din, bwe, clr, eccCe,
               output dout, rdDone, sbErr, dbErr);
  modport fab (input ref_clk, dout, rdDone, sbErr, dbErr,
               output en, dirSel, addr, din, bwe, clr, eccCe);
endinterface : drr_if

// *** core/drr_ram_dev.sv ***
// Dual-port 72-bit RAM block with output pipeline, clear modes and status flags
`timescale 1ns/1ps
module drr_ram_dev #(
  parameter logic                 CLK_FLIP    = 1'h0,
  parameter logic [1:0]           EN_FLIP     = 2'h0,
  parameter logic [1:0]           CLR_FLIP    = 2'h0,
  parameter logic [1:0]           DIR_FLIP    = 2'h0,
  parameter logic [1:0]           RST_ASYNC   = 2'h0,
  parameter logic [1:0]           IN_STAGE    = 2'h0,
  parameter logic [1:0]           ARR_ARRAY_OUTPUT_STAGE_REGISTER    = 2'h0,
  parameter logic [1:0]           ECC_ARRAY_OUTPUT_STAGE_REGISTER    = 2'h0,
  parameter logic [1:0]           CHAIN_STAGE = 2'h0,
  parameter logic [1:0]           ECC_WR      = 2'h0,
  parameter logic [1:0]           ECC_RD      = 2'h0,
  parameter drr_pkg::drr_bwe_t    BWE_A       = drr_pkg::BWE_INTERLEAVED,
  parameter drr_pkg::drr_bwe_t    BWE_B       = drr_pkg::BWE_INTERLEAVED,
  parameter drr_pkg::drr_cas_t    CAS_CTRL_A  = drr_pkg::CAS_NONE,
  parameter drr_pkg::drr_cas_t    CAS_CTRL_B  = drr_pkg::CAS_NONE,
  parameter drr_pkg::drr_cas_t    CAS_DATA_A  = drr_pkg::CAS_NONE,
  parameter drr_pkg::drr_cas_t    CAS_DATA_B  = drr_pkg::CAS_NONE,
  parameter logic                 AUTO_SLEEP  = 1'h0,
  parameter int                   SLEEP_LAT   = drr_pkg::SLEEP_LAT_DEF,
  // One group per entry; a single packed vector this wide overruns tool limits
  parameter logic [drr_pkg::GRP_W-1:0] INIT [drr_pkg::GRP_N] = '{default: '0}
) (
  drr_if.dev                              bus,
  input  wire logic                       srst,
  input  wire logic [1:0][drr_pkg::DATA_W-1:0] casDout,
  input  wire logic [1:0]                 casRdDone,
  input  wire logic [1:0]                 casSbErr,
  input  wire logic [1:0]                 casDbErr,
  output logic                            asleep
);
  localparam int LAT = (SLEEP_LAT < drr_pkg::SLEEP_LAT_MIN) ? drr_pkg::SLEEP_LAT_MIN :
                       (SLEEP_LAT > drr_pkg::SLEEP_LAT_MAX) ? drr_pkg::SLEEP_LAT_MAX :
                       SLEEP_LAT;

  wire logic                               memClk;
  wire logic [1:0]                         wrGo;
  wire logic [1:0]                         busy;
  wire logic [1:0][drr_pkg::ADDR_W-1:0]    opAddr;
  wire logic [1:0][drr_pkg::DATA_W-1:0]    wData;
  wire logic [1:0][drr_pkg::DATA_W-1:0]    wMask;
  logic                                    asleep_ff;
  logic                                    nxt_asleep;
  drr_pkg::drr_word_t                      mem [drr_pkg::WORDS];

  assign memClk = bus.ref_clk ^ CLK_FLIP;
  assign asleep = asleep_ff;

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  initial begin
    for (int g = 0; g < drr_pkg::GRP_N; g++) begin
      for (int j = 0; j < drr_pkg::GRP_WORDS; j++) begin
        mem[g*drr_pkg::GRP_WORDS+j] = INIT[g][j*drr_pkg::DATA_W +: drr_pkg::DATA_W];
      end
    end
  end

  // Port clears never reach here; port B wins a same-address collision
  always @(posedge memClk) begin
    for (int p = 0; p < 2; p++) begin
      if (wrGo[p]) begin
        mem[opAddr[p]] <= (mem[opAddr[p]] & ~wMask[p]) | (wData[p] & wMask[p]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Auto sleep: enables arrive early, window of lookahead empty means sleep
  // ----------------------------------------------------------------
  always_comb begin
    nxt_asleep = AUTO_SLEEP && !(|busy) && !srst;
  end

  always_ff @(posedge memClk) begin
    asleep_ff <= nxt_asleep;
  end

  // ----------------------------------------------------------------
  // Per-port logic
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int D = 1 + int'(ARR_ARRAY_OUTPUT_STAGE_REGISTER[p]) + int'(ECC_ARRAY_OUTPUT_STAGE_REGISTER[p]);
    localparam drr_pkg::drr_cas_t CD = (p == 0) ? CAS_DATA_A : CAS_DATA_B;
    localparam drr_pkg::drr_cas_t CC = (p == 0) ? CAS_CTRL_A : CAS_CTRL_B;
    localparam drr_pkg::drr_bwe_t BM = (p == 0) ? BWE_A : BWE_B;
    localparam logic CAS_USE = (CD == drr_pkg::CAS_MIDDLE) || (CD == drr_pkg::CAS_LAST);

    logic                          ipEn_ff, ipDir_ff, nxt_ipEn, nxt_ipDir;
    logic [drr_pkg::ADDR_W-1:0]    ipAddr_ff, nxt_ipAddr;
    drr_pkg::drr_word_t            ipDin_ff, nxt_ipDin;
    logic [drr_pkg::BYTE_N-1:0]    ipBwe_ff, nxt_ipBwe;
    logic [drr_pkg::SLEEP_LAT_MAX-1:0] look_ff, nxt_look;
    drr_pkg::drr_word_t            csD_ff, nxt_csD;
    logic                          csV_ff, csS_ff, csE_ff, nxt_csV, nxt_csS, nxt_csE;
    logic [drr_pkg::STAGE_MAX-1:0][drr_pkg::DATA_W-1:0] pd_ff, nxt_pd, inD;
    logic [drr_pkg::STAGE_MAX-1:0] pv_ff, ps_ff, pe_ff, nxt_pv, nxt_ps, nxt_pe;
    logic [drr_pkg::STAGE_MAX-1:0] inV, inS, inE;
    logic                          enRaw, enI, dirI, enOp, rdGo, rstAct, syncClr, asyncClr;
    logic                          take, casTake;
    logic [drr_pkg::ADDR_W-1:0]    addrI;
    drr_pkg::drr_word_t            dinI, rdWord;
    logic [drr_pkg::BYTE_N-1:0]    bweI;
    logic [drr_pkg::DATA_W+1:0]    dec;

    // Control order only records position; control nets are fed straight here
    assign enRaw    = bus.en[p] ^ EN_FLIP[p];
    assign enI      = IN_STAGE[p] ? ipEn_ff : enRaw;
    assign dirI     = IN_STAGE[p] ? ipDir_ff : (bus.dirSel[p] ^ DIR_FLIP[p]);
    assign addrI    = IN_STAGE[p] ? ipAddr_ff : bus.addr[p];
    assign dinI     = IN_STAGE[p] ? ipDin_ff : bus.din[p];
    assign bweI     = IN_STAGE[p] ? ipBwe_ff : bus.bwe[p];
    assign enOp     = AUTO_SLEEP ? look_ff[LAT-1] : enI;
    assign busy[p]  = (|look_ff[LAT-1:0]) | enI;
    assign rdGo     = enOp && !dirI && !asleep_ff;
    assign wrGo[p]  = enOp && dirI && !asleep_ff;
    assign opAddr[p] = addrI;
    assign wData[p] = ECC_WR[p] ? drr_pkg::drr_ecc_enc(dinI[drr_pkg::LOW_W-1:0]) : dinI;
    assign rstAct   = bus.clr[p] ^ CLR_FLIP[p];
    assign syncClr  = srst || (rstAct && !RST_ASYNC[p]);
    assign asyncClr = rstAct && RST_ASYNC[p];
    assign rdWord   = mem[addrI];
    assign dec      = drr_pkg::drr_ecc_dec(rdWord);

    // Byte lanes; ECC writes always take the whole word
    for (genvar b = 0; b < drr_pkg::BYTE_N - 1; b++) begin : g_lane
      assign wMask[p][8*b +: 8] = ECC_WR[p] ? 8'hff : {8{bweI[b]}};
      assign wMask[p][drr_pkg::LOW_W+b] = ECC_WR[p] ||
             ((BM == drr_pkg::BWE_INTERLEAVED) ? bweI[b] : bweI[drr_pkg::BYTE_N-1]);
    end

    // Input and chain stages ignore port clears, so reads in flight may surface
    always_comb begin
      nxt_ipEn   = srst ? 1'h0 : enRaw;
      nxt_ipDir  = bus.dirSel[p] ^ DIR_FLIP[p];
      nxt_ipAddr = bus.addr[p];
      nxt_ipDin  = bus.din[p];
      nxt_ipBwe  = bus.bwe[p];
      nxt_look   = srst ? '0 : {look_ff[drr_pkg::SLEEP_LAT_MAX-2:0], enI};
      nxt_csV    = srst ? 1'h0 : casRdDone[p];
      nxt_csD    = casDout[p];
      nxt_csS    = casSbErr[p];
      nxt_csE    = casDbErr[p];
    end

    always_ff @(posedge memClk) begin
      ipEn_ff   <= nxt_ipEn;
      ipDir_ff  <= nxt_ipDir;
      ipAddr_ff <= nxt_ipAddr;
      ipDin_ff  <= nxt_ipDin;
      ipBwe_ff  <= nxt_ipBwe;
      look_ff   <= nxt_look;
      csV_ff    <= nxt_csV;
      csD_ff    <= nxt_csD;
      csS_ff    <= nxt_csS;
      csE_ff    <= nxt_csE;
    end

    // Output pipeline: stage 0 array out, then optional array stage, then optional ECC stage
    always_comb begin
      inD     = {pd_ff[1:0], (ECC_RD[p] ? dec[drr_pkg::DATA_W-1:0] : rdWord)};
      inV     = {pv_ff[1:0], rdGo};
      inS     = {ps_ff[1:0], ECC_RD[p] && dec[drr_pkg::DATA_W]};
      inE     = {pe_ff[1:0], ECC_RD[p] && dec[drr_pkg::DATA_W+1]};
      nxt_pd  = pd_ff;
      nxt_ps  = ps_ff;
      nxt_pe  = pe_ff;
      nxt_pv  = '0;
      take    = 1'h0;
      casTake = 1'h0;
      for (int k = 0; k < D; k++) begin
        take = inV[k] && !(ECC_ARRAY_OUTPUT_STAGE_REGISTER[p] && k == D - 1 && !bus.eccCe[p]);
        casTake = CAS_USE && (k == D - 1) && !take &&
                  (CHAIN_STAGE[p] ? csV_ff : casRdDone[p]);
        if (take) begin
          nxt_pd[k] = inD[k];
          nxt_ps[k] = inS[k];
          nxt_pe[k] = inE[k];
        end else if (casTake) begin
          nxt_pd[k] = CHAIN_STAGE[p] ? csD_ff : casDout[p];
          nxt_ps[k] = CHAIN_STAGE[p] ? csS_ff : casSbErr[p];
          nxt_pe[k] = CHAIN_STAGE[p] ? csE_ff : casDbErr[p];
        end
        nxt_pv[k] = take || casTake;
        if (asleep_ff && (k == 0 || (k == 1 && ARR_ARRAY_OUTPUT_STAGE_REGISTER[p]))) begin
          nxt_pd[k] = drr_pkg::DOUT_RST;
          nxt_ps[k] = 1'h0;
          nxt_pe[k] = 1'h0;
        end
      end
      if (syncClr) begin
        nxt_pd = '0;
        nxt_pv = '0;
        nxt_ps = '0;
        nxt_pe = '0;
      end
    end

    always_ff @(posedge memClk or posedge asyncClr) begin
      if (asyncClr) begin
        pd_ff <= '0;
        pv_ff <= '0;
        ps_ff <= '0;
        pe_ff <= '0;
      end else begin
        pd_ff <= nxt_pd;
        pv_ff <= nxt_pv;
        ps_ff <= nxt_ps;
        pe_ff <= nxt_pe;
      end
    end

    // Full 72-bit word leaves the last stage; also feeds the next block's chain input
    assign bus.dout[p]   = pd_ff[D-1];
    assign bus.rdDone[p] = pv_ff[D-1];
    assign bus.sbErr[p]  = ps_ff[D-1];
    assign bus.dbErr[p]  = pe_ff[D-1];
  end
endmodule : drr_ram_dev

// *** core/drr_fab_host.sv ***
// Fabric end driving both RAM ports, with clear synchroniser and output hold
`timescale 1ns/1ps
module drr_fab_host #(
  parameter logic [1:0] EN_FLIP  = 2'h0,
  parameter logic [1:0] CLR_FLIP = 2'h0,
  parameter logic [1:0] DIR_FLIP = 2'h0
) (
  drr_if.fab                                   bus,
  input  wire logic                            srst,
  input  wire logic                            usrClrReq,
  input  wire logic [1:0]                      usrReq,
  input  wire logic [1:0]                      usrWr,
  input  wire logic [1:0][drr_pkg::ADDR_W-1:0] usrAddr,
  input  wire logic [1:0][drr_pkg::DATA_W-1:0] usrWdata,
  input  wire logic [1:0][drr_pkg::BYTE_N-1:0] usrBwe,
  input  wire logic [1:0]                      usrCapture,
  output logic [1:0][drr_pkg::DATA_W-1:0]      rdData,
  output logic [1:0]                           rdValid,
  output logic [1:0]                           rdSbErr,
  output logic [1:0]                           rdDbErr,
  output logic                                 clrBusy
);
  typedef enum {HS_RUN, HS_CLEAR} drr_hstate_t;

  drr_hstate_t                        st_ff, nxt_st;
  logic [drr_pkg::SYNC_LEN-1:0]       syn_ff, nxt_syn;
  logic [1:0]                         en_ff, dir_ff, clr_ff, ce_ff;
  logic [1:0]                         nxt_en, nxt_dir, nxt_clr, nxt_ce;
  logic [1:0][drr_pkg::ADDR_W-1:0]    addr_ff, nxt_addr;
  logic [1:0][drr_pkg::DATA_W-1:0]    din_ff, nxt_din, rdData_ff, nxt_rdData;
  logic [1:0][drr_pkg::BYTE_N-1:0]    bwe_ff, nxt_bwe;
  logic [1:0]                         rdValid_ff, rdSb_ff, rdDb_ff;
  logic [1:0]                         nxt_rdValid, nxt_rdSb, nxt_rdDb;
  logic                               clrBusy_ff, nxt_clrBusy;

  // ----------------------------------------------------------------
  // Clear sequencing
  // ----------------------------------------------------------------
  // One synchronised level feeds both ports so every block sees the same edge
  always_comb begin
    nxt_syn = srst ? '0 : {syn_ff[0], usrClrReq};
    case (st_ff)
      HS_RUN:   nxt_st = syn_ff[1] ? HS_CLEAR : HS_RUN;
      HS_CLEAR: nxt_st = syn_ff[1] ? HS_CLEAR : HS_RUN;
      default:  nxt_st = HS_RUN;
    endcase
    if (srst) nxt_st = HS_RUN;
    nxt_clrBusy = (nxt_st == HS_CLEAR);
    nxt_clr     = {2{nxt_clrBusy}} ^ CLR_FLIP;
  end

  always_ff @(posedge bus.ref_clk) begin
    syn_ff     <= nxt_syn;
    st_ff      <= nxt_st;
    clrBusy_ff <= nxt_clrBusy;
    clr_ff     <= nxt_clr;
  end

  // ----------------------------------------------------------------
  // Commands, registered on the reference clock
  // ----------------------------------------------------------------
  always_comb begin
    nxt_en   = (srst ? 2'h0 : usrReq) ^ EN_FLIP;
    nxt_dir  = usrWr ^ DIR_FLIP;
    nxt_addr = usrAddr;
    nxt_din  = usrWdata;
    nxt_bwe  = usrBwe;
    nxt_ce   = srst ? 2'h0 : usrCapture;
  end

  always_ff @(posedge bus.ref_clk) begin
    en_ff   <= nxt_en;
    dir_ff  <= nxt_dir;
    addr_ff <= nxt_addr;
    din_ff  <= nxt_din;
    bwe_ff  <= nxt_bwe;
    ce_ff   <= nxt_ce;
  end

  // ----------------------------------------------------------------
  // Read return: take data only on a done flag, hold otherwise
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdData  = rdData_ff;
    nxt_rdSb    = rdSb_ff;
    nxt_rdDb    = rdDb_ff;
    nxt_rdValid = srst ? 2'h0 : bus.rdDone;
    for (int p = 0; p < 2; p++) begin
      if (bus.rdDone[p]) begin
        nxt_rdData[p] = bus.dout[p];
        nxt_rdSb[p]   = bus.sbErr[p];
        nxt_rdDb[p]   = bus.dbErr[p];
      end
    end
    if (srst) begin
      nxt_rdData = '0;
      nxt_rdSb   = '0;
      nxt_rdDb   = '0;
    end
  end

  always_ff @(posedge bus.ref_clk) begin
    rdData_ff  <= nxt_rdData;
    rdValid_ff <= nxt_rdValid;
    rdSb_ff    <= nxt_rdSb;
    rdDb_ff    <= nxt_rdDb;
  end

  assign bus.en     = en_ff;
  assign bus.dirSel = dir_ff;
  assign bus.addr   = addr_ff;
  assign bus.din    = din_ff;
  assign bus.bwe    = bwe_ff;
  assign bus.clr    = clr_ff;
  assign bus.eccCe  = ce_ff;
  assign rdData     = rdData_ff;
  assign rdValid    = rdValid_ff;
  assign rdSbErr    = rdSb_ff;
  assign rdDbErr    = rdDb_ff;
  assign clrBusy    = clrBusy_ff;
endmodule : drr_fab_host

// *** verif/drr_ram_properties.sv ***
// Interface properties of the dual-port RAM block and its fabric end
`timescale 1ns/1ps
module drr_ram_properties (
  input wire logic                            ref_clk,
  input wire logic                            srst,
  input wire logic [1:0]                      en,
  input wire logic [1:0]                      dirSel,
  input wire logic [1:0]                      clr,
  input wire logic [1:0][drr_pkg::DATA_W-1:0] dout,
  input wire logic [1:0]                      rdDone,
  input wire logic [1:0]                      sbErr,
  input wire logic [1:0]                      dbErr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // --------------------------------------------------
  // Per-port timing, default options: no extra stages
  // --------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    rd_latency_a: assert property (en[p] && !dirSel[p] && !clr[p] |=> rdDone[p])
      else $error("read done missing one cycle after read");
    no_spurious_done_a: assert property (rdDone[p] |-> $past(en[p]) && !$past(dirSel[p])
      && !$past(clr[p]) && !$past(srst))
      else $error("read done without a read");
    dout_hold_a: assert property (!rdDone[p] && !$past(clr[p]) && !$past(srst)
      |-> $stable(dout[p]))
      else $error("data out changed without a read");
    clr_zero_a: assert property (clr[p] |=> dout[p] == drr_pkg::DOUT_RST && !rdDone[p]
      && !sbErr[p] && !dbErr[p])
      else $error("port clear left outputs set");
    write_hold_a: assert property (en[p] && dirSel[p] && !clr[p]
      |-> ##1 (!rdDone[p] && $stable(dout[p])))
      else $error("write disturbed read outputs");
    idle_quiet_a: assert property (!en[p] && !clr[p] |=> !rdDone[p] && $stable(dout[p]))
      else $error("idle port changed outputs");
  end

  // --------------------------------------------------
  // Whole-block relations
  // --------------------------------------------------
  flags_zero_a: assert property ((sbErr | dbErr) == 2'h0)
    else $error("error flag raised with decoder off");
  clr_together_a: assert property (clr[0] == clr[1])
    else $error("port clears not driven together");

  cover property (rdDone[0] && rdDone[1]);
  cover property (rdDone[0] [*2]);
  cover property (en[0] && dirSel[0] && en[1] && !dirSel[1]);
  cover property ($rose(clr[0]));
endmodule : drr_ram_properties

// *** verif/dual_port_ram_output_reset_status_bench.sv ***
// Self-checking bench: fabric end and RAM block joined by their interface
`timescale 1ns/1ps
module dual_port_ram_output_reset_status_bench;
  // --------------------------------------------------
  // Signals
  // --------------------------------------------------
  logic                            ref_clk;
  logic                            srst;
  logic                            usrClrReq;
  logic [1:0]                      usrReq;
  logic [1:0]                      usrWr;
  logic [1:0]                      usrCapture;
  logic [1:0][drr_pkg::ADDR_W-1:0] usrAddr;
  logic [1:0][drr_pkg::DATA_W-1:0] usrWdata;
  logic [1:0][drr_pkg::BYTE_N-1:0] usrBwe;
  logic [1:0][drr_pkg::DATA_W-1:0] rdData;
  logic [1:0]                      rdValid;
  logic [1:0]                      rdSbErr;
  logic [1:0]                      rdDbErr;
  logic                            clrBusy;
  logic                            asleep;
  drr_pkg::drr_word_t              refMem [drr_pkg::WORDS];
  drr_pkg::drr_word_t              expQ [2][$];
  int                              dueQ [2][$];
  int                              fail_count;
  int                              cmp_count;
  int                              ncnt;

  drr_if bus (.ref_clk(ref_clk));
  // Chain inputs unused: single block, no cascade below
  drr_ram_dev drr_ram_dev_inst (.bus(bus), .srst(srst), .casDout('0), .casRdDone(2'h0),
    .casSbErr(2'h0), .casDbErr(2'h0), .asleep(asleep));
  drr_fab_host drr_fab_host_inst (.bus(bus), .srst(srst), .usrClrReq(usrClrReq),
    .usrReq(usrReq), .usrWr(usrWr), .usrAddr(usrAddr), .usrWdata(usrWdata), .usrBwe(usrBwe),
    .usrCapture(usrCapture), .rdData(rdData), .rdValid(rdValid), .rdSbErr(rdSbErr),
    .rdDbErr(rdDbErr), .clrBusy(clrBusy));
  drr_ram_properties drr_ram_properties_inst (.ref_clk(ref_clk), .srst(srst), .en(bus.en),
    .dirSel(bus.dirSel), .clr(bus.clr), .dout(bus.dout), .rdDone(bus.rdDone),
    .sbErr(bus.sbErr), .dbErr(bus.dbErr));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic drr_pkg::drr_word_t merge(input drr_pkg::drr_word_t o,
    input drr_pkg::drr_word_t n, input logic [drr_pkg::BYTE_N-1:0] be);
    drr_pkg::drr_word_t r;
    r = o;
    for (int b = 0; b < 8; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
        r[64+b]     = n[64+b];
      end
    end
    return r;
  endfunction : merge

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Reads are modelled before writes of the same cycle: the array updates one edge later
  task automatic cycle(input logic [1:0] rq, input logic [1:0] wr,
    input logic [1:0][drr_pkg::ADDR_W-1:0] ad, input logic [1:0][drr_pkg::DATA_W-1:0] wd,
    input logic [1:0][drr_pkg::BYTE_N-1:0] be);
    @(posedge ref_clk);
    usrReq     <= rq;
    usrWr      <= wr;
    usrAddr    <= ad;
    usrWdata   <= wd;
    usrBwe     <= be;
    usrCapture <= 2'($urandom);
    for (int p = 0; p < 2; p++) begin
      if (rq[p] && !wr[p]) begin
        expQ[p].push_back(refMem[ad[p]]);
        dueQ[p].push_back(ncnt + 4);
      end
    end
    // Shared address: port B's enabled bytes go into the old word, port A's bytes are lost
    for (int p = 0; p < 2; p++) begin
      if (rq[p] && wr[p] && !(p == 0 && rq[1] && wr[1] && ad[1] == ad[0])) begin
        refMem[ad[p]] = merge(refMem[ad[p]], wd[p], be[p]);
      end
    end
  endtask : cycle

  task automatic idle(input int n);
    repeat (n) cycle(2'h0, 2'h0, '0, '0, '0);
  endtask : idle

  function automatic drr_pkg::drr_word_t rword();
    return {8'($urandom), $urandom, $urandom};
  endfunction : rword

  // --------------------------------------------------
  // Read-return monitor, sampled mid-cycle
  // --------------------------------------------------
  always @(negedge ref_clk) begin
    ncnt++;
    for (int p = 0; p < 2; p++) begin
      if (rdValid[p] === 1'b1) begin
        check(expQ[p].size() != 0, "unexpected read valid");
        if (expQ[p].size() != 0) begin
          check(dueQ[p][0] == ncnt, "read latency");
          check(rdData[p] === expQ[p][0], "read data");
          check({rdSbErr[p], rdDbErr[p]} === 2'h0, "error flags");
          void'(expQ[p].pop_front());
          void'(dueQ[p].pop_front());
        end
      end else if (expQ[p].size() != 0 && dueQ[p][0] <= ncnt) begin
        check(1'b0, "read result missing");
        void'(expQ[p].pop_front());
        void'(dueQ[p].pop_front());
      end
    end
  end

  initial begin
    #(2000 * 50);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    drr_pkg::drr_word_t x;
    srst = 1'b1;
    usrClrReq = 1'b0;
    usrReq = 2'h0;
    usrWr = 2'h0;
    usrCapture = 2'h0;
    usrAddr = '0;
    usrWdata = '0;
    usrBwe = '0;
    fail_count = 0;
    cmp_count = 0;
    ncnt = 0;
    foreach (refMem[i]) refMem[i] = '0;
    void'($urandom(89));
    x = rword();
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    // Write A and read B of one word in one cycle, then read back at once
    cycle(2'h3, 2'h1, {12'h005, 12'h005}, {72'h0, x}, {9'h000, 9'h1ff});
    cycle(2'h3, 2'h1, {12'h005, 12'h005}, {72'h0, ~x}, {9'h000, 9'h001});
    cycle(2'h3, 2'h3, {12'hfff, 12'hfff}, {x, ~x}, {9'h1ff, 9'h1ff});
    cycle(2'h3, 2'h0, {12'hfff, 12'h005}, '0, '0);
    cycle(2'h1, 2'h0, {12'h0, 12'hfff}, '0, '0);
    for (int i = 0; i < 400; i++) begin
      cycle(2'($urandom), 2'($urandom), {12'($urandom % 16), 12'($urandom % 16)},
        {rword(), rword()}, {($urandom % 4 == 0) ? 9'h1ff : 9'($urandom), 9'($urandom)});
    end
    idle(6);
    // Port clear, with writes landing while it is held
    usrClrReq <= 1'b1;
    idle(5);
    check(clrBusy === 1'b1, "clear not active");
    check(bus.dout === '0, "outputs not cleared");
    for (int i = 0; i < 4; i++) begin
      cycle(2'h3, 2'h3, {12'(i + 8), 12'(i)}, {rword(), rword()}, {9'h1ff, 9'h0ff});
    end
    usrClrReq <= 1'b0;
    idle(6);
    check(clrBusy === 1'b0, "clear stuck");
    for (int i = 0; i < 16; i++) begin
      cycle(2'h3, 2'h0, {12'(15 - i), 12'(i)}, '0, '0);
    end
    idle(6);
    check(expQ[0].size() == 0 && expQ[1].size() == 0, "reads left over");
    check(asleep === 1'b0, "block asleep with sleep off");
    stop_test();
  end
endmodule : dual_port_ram_output_reset_status_bench
